//--- tb_transient_drive_and_fault_shutdown.sv
// Purpose: Self-checking bench for the power-stage transient and fault logic
// Assumes: Inputs change 1 ns after the rising edge; pulses checked one cycle on
// Notes:   Peak test runs first, since any fault latches the controller model off
`timescale 1ns/1ps
module tb_transient_drive_and_fault_shutdown;
  import tdfs_pkg::*;
  logic        CLOCK, RST_B, PWM_IN, PERIOD_START, FAULT_CLR, HS_GATE, sync_hs, ls_drv, shut;
  logic [7:0]  SENSE_CODE, VOLTAGE_ID_CODE, TEMP_C, PHASE_CURRENT, TRANSIENT_REF, t;
  logic [4:0]  OVER_OFS, UNDER_OFS, OOV_OFS, OUV_OFS;
  logic [15:0] VIN_MV;
  logic [2:0]  OT_SEL;
  logic [1:0]  ILIM_SEL;
  tdfs_atr_t   ATR_PULSE;
  tdfs_fault_t STATUS, FAULT_REG;
  int          errors = 0;   // Mismatch count
  int          n_tests = 0;  // Comparison count
  tdfs_stage tdfs_stage_i (.CLOCK(CLOCK), .RST_B(RST_B), .SENSE_CODE(SENSE_CODE),
    .VOLTAGE_ID_CODE(VOLTAGE_ID_CODE), .OVER_OFS(OVER_OFS), .UNDER_OFS(UNDER_OFS),
    .OOV_OFS(OOV_OFS), .OUV_OFS(OUV_OFS), .VIN_MV(VIN_MV), .TEMP_C(TEMP_C), .OT_SEL(OT_SEL),
    .PHASE_CURRENT(PHASE_CURRENT), .ILIM_SEL(ILIM_SEL), .PWM_IN(PWM_IN),
    .PERIOD_START(PERIOD_START), .FAULT_CLR(FAULT_CLR), .ATR_PULSE(ATR_PULSE),
    .TRANSIENT_REF(TRANSIENT_REF), .STATUS(STATUS), .FAULT_REG(FAULT_REG), .HS_GATE(HS_GATE));
  tdfs_ctrl_model tdfs_ctrl_model_i (.clk(CLOCK), .rst_b(RST_B), .sync_high_side_signal(sync_hs),
    .sync_low_side_signal(1'b0), .active_transient_response(ATR_PULSE), .fault(FAULT_REG), .pwm(PWM_IN),
    .low_side_drive(ls_drv), .shut_r(shut));
  // Free-running 10 MHz clock
  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end
  // Let n edges pass, then settle past the drive delay
  task automatic step(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : step
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %b got %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_vec(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk_vec
  // One-cycle pulses; a clear is taken on the edge it spans
  task automatic pulse_clr;
    FAULT_CLR = 1'b1;
    step(1);
    FAULT_CLR = 1'b0;
  endtask : pulse_clr
  task automatic pulse_start;
    PERIOD_START = 1'b1;
    step(1);
    PERIOD_START = 1'b0;
  endtask : pulse_start
  // Each limit step: at limit keeps gate, one above cuts until next period
  task automatic t_peak;
    for (int i = 0; i < 4; i++) begin
      ILIM_SEL = 2'(i);
      t = 8'h40 + 8'h20 * 8'(i);
      PHASE_CURRENT = t;
      pulse_start();
      step(1);
      chk_bit("hs_at_limit", 1'b1, HS_GATE);
      PHASE_CURRENT = t + 8'h01;
      step(1);
      chk_bit("hs_cut", 1'b0, HS_GATE);
      PHASE_CURRENT = 8'h00;
      step(2);
      chk_bit("hs_held", 1'b0, HS_GATE);
      chk_vec("no_fault", 8'h00, {4'h0, FAULT_REG});
      pulse_start();
      chk_bit("hs_new_period", 1'b1, HS_GATE);
    end
  endtask : t_peak
  // Window edges around a moved reference, offsets 4 above and 3 below
  task automatic t_window;
    logic [7:0] s [5] = '{8'h80, 8'h94, 8'h95, 8'h8D, 8'h8C};
    logic [1:0] e [5] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h1};
    VOLTAGE_ID_CODE = 8'h90;
    step(1);
    chk_vec("ref", 8'h90, TRANSIENT_REF);
    for (int i = 0; i < 5; i++) begin
      SENSE_CODE = s[i];
      step(1);
      chk_vec("atr", {6'h00, e[i]}, {6'h00, ATR_PULSE});
    end
    SENSE_CODE = 8'h90;
  endtask : t_window
  // Input supply: sets below 7600, clears only above 9100
  task automatic t_iuv;
    VIN_MV = 16'h1DB0;
    step(2);
    chk_bit("iuv_at_set", 1'b0, STATUS.iuv);
    VIN_MV = 16'h1DAF;
    step(1);
    chk_bit("iuv_set", 1'b1, STATUS.iuv);
    step(1);
    chk_bit("iuv_fault", 1'b1, FAULT_REG.iuv);
    VIN_MV = 16'h238C;
    step(2);
    chk_bit("iuv_at_clr", 1'b1, STATUS.iuv);
    VIN_MV = 16'h238D;
    step(1);
    chk_bit("iuv_clr", 1'b0, STATUS.iuv);
    step(1);
    pulse_clr();
    chk_bit("iuv_fault_clr", 1'b0, FAULT_REG.iuv);
  endtask : t_iuv
  // Every trip selection, codes above 6 clamp to the top trip
  task automatic t_ot;
    for (int i = 0; i < 8; i++) begin
      OT_SEL = 3'(i);
      t = 8'h55 + 8'h0A * ((i > 6) ? 8'h06 : 8'(i));
      TEMP_C = t - 8'h01;
      step(2);
      chk_bit("ot_below", 1'b0, STATUS.ot);
      TEMP_C = t;
      step(1);
      chk_bit("ot_trip", 1'b1, STATUS.ot);
      step(1);
      chk_bit("ot_fault", 1'b1, FAULT_REG.ot);
      TEMP_C = t - 8'h0A;
      step(2);
      chk_bit("ot_hyst", 1'b1, STATUS.ot);
      TEMP_C = t - 8'h0B;
      step(2);
      chk_bit("ot_clr", 1'b0, STATUS.ot);
      pulse_clr();
      chk_bit("ot_fault_clr", 1'b0, FAULT_REG.ot);
    end
  endtask : t_ot
  // Output window at the largest offset, refused clear while still beyond
  task automatic t_volt;
    logic [7:0] ok_s [2] = '{8'hAF, 8'h71};
    logic [7:0] bad_s [2] = '{8'hB0, 8'h70};
    logic [7:0] e [2] = '{8'h02, 8'h04};
    for (int i = 0; i < 2; i++) begin
      SENSE_CODE = ok_s[i];
      step(1);
      chk_vec("volt_ok", 8'h00, {4'h0, FAULT_REG});
      SENSE_CODE = bad_s[i];
      step(1);
      chk_vec("volt_bad", e[i], {4'h0, FAULT_REG});
      pulse_clr();
      chk_vec("volt_refused", e[i], {4'h0, FAULT_REG});
      SENSE_CODE = 8'h90;
      step(1);
      pulse_clr();
      chk_vec("volt_clr", 8'h00, {4'h0, FAULT_REG});
    end
    chk_bit("ctrl_shut", 1'b1, shut);
    chk_bit("ctrl_pwm_off", 1'b0, PWM_IN);
  endtask : t_volt
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // Quiet levels at time zero: no fault, no transient, gate commanded on
  initial begin
    {RST_B, PERIOD_START, FAULT_CLR, OT_SEL, ILIM_SEL, PHASE_CURRENT} = '0;
    // Codes start at the reset reference so no window trips on the first edge
    {SENSE_CODE, VOLTAGE_ID_CODE, TEMP_C} = {8'h00, 8'h00, 8'h19};
    {OVER_OFS, UNDER_OFS, OOV_OFS, OUV_OFS} = {5'h04, 5'h03, 5'h1F, 5'h1F};
    VIN_MV = 16'h2EE0;
    sync_hs = 1'b1;
    step(3);
    RST_B = 1'b1;
    step(2);
    t_peak();
    t_window();
    t_iuv();
    t_ot();
    t_volt();
    end_of_test();
  end
  // Watchdog: the run needs about 126 cycles
  initial begin
    repeat (2000) @(posedge CLOCK);
    errors++;
    end_of_test();
  end
endmodule : tb_transient_drive_and_fault_shutdown

//--- tdfs_ctrl_model.sv
// Purpose: Behavioural controller facing the power stage: drive combining, shutdown latch
// Assumes: One clock; transient pulses arrive already registered by the stage
// Notes:   Quiet exit after one clock (100 ns), inside the allowed exit interval
`timescale 1ns/1ps
module tdfs_ctrl_model
  import tdfs_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_b,
  input  wire logic  sync_high_side_signal,
  input  wire logic  sync_low_side_signal,
  input  tdfs_atr_t  active_transient_response,
  input  tdfs_fault_t fault,
  output logic       pwm,
  output logic       low_side_drive,
  output logic       shut_r
);
  logic [1:0] mode_r;  // Held mode: 0 none, 1 overshoot, 2 undershoot
  logic [1:0] mode;    // Mode seen this cycle, so a first pulse acts at once
  assign mode = (mode_r != 2'h0) ? mode_r : active_transient_response.over ? 2'h1 : active_transient_response.under ? 2'h2 : 2'h0;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) mode_r <= 2'h0;
    else if (!active_transient_response.over && !active_transient_response.under) mode_r <= 2'h0;
    else mode_r <= mode;
  end
  // any polled fault latches until supply reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) shut_r <= 1'b0;
    else if (|fault) shut_r <= 1'b1;
  end
  // duty limit: not modelled; the bench holds the high-side command on for the whole run
  assign pwm = (!rst_b || shut_r || mode == 2'h1) ? 1'b0
             : sync_high_side_signal | (mode == 2'h2 && active_transient_response.under);
  assign low_side_drive = (!rst_b || shut_r || mode == 2'h2) ? 1'b0
             : sync_low_side_signal | (mode == 2'h1 && active_transient_response.over);
endmodule : tdfs_ctrl_model

//--- tdfs_hyst.sv
// Purpose: Threshold comparator with hysteresis for slow analog quantities
// Assumes: Value and thresholds are codes synchronous to clk
// Notes:   ABOVE=1 trips at or above trip, else trips below trip
`timescale 1ns/1ps
module tdfs_hyst #(
  parameter int W     = 16,
  parameter bit ABOVE = 1'b1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] trip,
  input  wire logic [W-1:0] rel_lvl,
  output logic              flag
);

  // Width sanity
  initial begin
    if (W < 2) $error("tdfs_hyst: W must be at least 2");
  end

  logic flag_r;    // Tripped state
  logic flag_nxt;  // Next tripped state

  // Trip and release decisions; release needs crossing the far level
  always_comb begin
    flag_nxt = flag_r;
    if (ABOVE) begin
      if (value >= trip) flag_nxt = 1'b1;
      else if (value < rel_lvl) flag_nxt = 1'b0;
    end else begin
      if (value < trip) flag_nxt = 1'b1;
      else if (value > rel_lvl) flag_nxt = 1'b0;
    end
  end

  // Register only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) flag_r <= 1'b0;
    else flag_r <= flag_nxt;
  end

  assign flag = flag_r;

endmodule : tdfs_hyst

//--- tdfs_params.svh
// Purpose: Constants for the transient drive and fault shutdown power-stage logic
// Assumes: Voltage codes use one LSB of 7.5 mV, input supply in mV, temperature in degrees C
// Notes:   Definitions only
`ifndef TDFS_PARAMS_SVH
`define TDFS_PARAMS_SVH

// Sense and offset code widths
`define TDFS_SENSE_W      8
`define TDFS_OFS_W        5
// One code step in microvolts
`define TDFS_STEP_UV      7500
// Input undervoltage set and clear levels, mV
`define TDFS_IUV_SET_MV   16'd7600
`define TDFS_IUV_CLR_MV   16'd9100
// Overtemperature trip selection
`define TDFS_OT_BASE_C    8'd85
`define TDFS_OT_STEP_C    8'd10
`define TDFS_OT_MAX_SEL   3'h6
`define TDFS_OT_HYST_C    8'd10
// Peak current limit selection width (four steps)
`define TDFS_ILIM_SEL_W   2
// Reset values
`define TDFS_FAULT_RST    4'h0
`define TDFS_CODE_RST     8'h00

`endif

//--- tdfs_pkg.sv
// Purpose: Types shared by the transient drive and fault shutdown logic
// Assumes: Constants live in tdfs_params.svh
// Notes:   Fault bit order matches the fault register layout
package tdfs_pkg;

  // Fault and status bits, one per protection
  typedef struct packed {
    logic iuv;   // Input undervoltage
    logic ouv;   // Output undervoltage
    logic oov;   // Output overvoltage
    logic ot;    // Overtemperature
  } tdfs_fault_t;

  // Transient pulse pair
  typedef struct packed {
    logic over;   // Overshoot pulse
    logic under;  // Undershoot pulse
  } tdfs_atr_t;

endpackage : tdfs_pkg

//--- tdfs_stage.sv
// Purpose: Power-stage logic: transient window comparator, fault register, peak current limit
// Assumes: All inputs synchronous to CLOCK (10 MHz); analog values arrive as digital codes
// Notes:   The controller side (drive combining, shutdown latch) lives outside this block
`timescale 1ns/1ps
`include "tdfs_params.svh"
module tdfs_stage
  import tdfs_pkg::*;
#(
  parameter int SW         = `TDFS_SENSE_W,  // Sense code width
  parameter int OW         = `TDFS_OFS_W,    // Offset code width
  parameter int IW         = 8,              // Phase current code width
  parameter int ILIM_BASE  = 64,             // Lowest peak limit code
  parameter int ILIM_STEP  = 32              // Code added per limit step
) (
  input  wire logic                          CLOCK,
  input  wire logic                          RST_B,
  input  wire logic [SW-1:0]                 SENSE_CODE,
  input  wire logic [SW-1:0]                 VOLTAGE_ID_CODE,
  input  wire logic [OW-1:0]                 OVER_OFS,
  input  wire logic [OW-1:0]                 UNDER_OFS,
  input  wire logic [OW-1:0]                 OOV_OFS,
  input  wire logic [OW-1:0]                 OUV_OFS,
  input  wire logic [15:0]                   VIN_MV,
  input  wire logic [7:0]                    TEMP_C,
  input  wire logic [2:0]                    OT_SEL,
  input  wire logic [IW-1:0]                 PHASE_CURRENT,
  input  wire logic [`TDFS_ILIM_SEL_W-1:0]   ILIM_SEL,
  input  wire logic                          PWM_IN,
  input  wire logic                          PERIOD_START,
  input  wire logic                          FAULT_CLR,
  output tdfs_atr_t                          ATR_PULSE,
  output logic [SW-1:0]                      TRANSIENT_REF,
  output tdfs_fault_t                        STATUS,
  output tdfs_fault_t                        FAULT_REG,
  output logic                               HS_GATE
);

  // Parameters the logic cannot serve are refused
  initial begin
    if (SW < 4 || OW < 1 || OW > SW) $error("tdfs_stage: bad code widths");
    if (ILIM_BASE + 3 * ILIM_STEP >= (1 << IW)) $error("tdfs_stage: peak limit overflows");
  end

  // Transient reference and window comparator state
  logic [SW-1:0] ref_r,   ref_nxt;    // Transient reference
  logic [SW-1:0] vid_r,   vid_nxt;    // Last voltage code seen
  tdfs_atr_t     atr_r,   atr_nxt;    // Registered transient pulses
  // Fault state
  tdfs_fault_t   status_live;         // Live status from comparators
  tdfs_fault_t   fault_r, fault_nxt;  // Sticky fault register
  // Peak current limiter state
  logic          cut_r,   cut_nxt;    // High side cut for rest of period
  logic          hs_r,    hs_nxt;     // Registered high-side gate
  // Derived thresholds; the four window sums are one bit wider to avoid wrap
  logic [SW:0]   over_lvl;            // Reference plus overshoot offset
  logic [SW:0]   under_chk;           // Sense plus undershoot offset
  logic [SW:0]   oov_lvl;             // Reference plus overvoltage offset
  logic [SW:0]   ouv_chk;             // Sense plus undervoltage offset
  logic [IW-1:0] ilim;                // Selected peak limit
  logic [2:0]    ot_sel_c;            // Clamped trip selection
  logic [7:0]    ot_trip;             // Trip temperature
  logic [7:0]    ot_rel;              // Release temperature
  logic          iuv_flag;            // Input undervoltage comparator
  logic          ot_flag;             // Overtemperature comparator

  // offsets add as codes
  // One sense LSB equals one offset step, so no scaling is needed
  assign over_lvl  = {1'b0, ref_r} + {{(SW+1-OW){1'b0}}, OVER_OFS};
  assign under_chk = {1'b0, SENSE_CODE} + {{(SW+1-OW){1'b0}}, UNDER_OFS};
  assign oov_lvl   = {1'b0, ref_r} + {{(SW+1-OW){1'b0}}, OOV_OFS};
  assign ouv_chk   = {1'b0, SENSE_CODE} + {{(SW+1-OW){1'b0}}, OUV_OFS};

  // compare sense, reference
  // Reference tracking and pulse generation
  always_comb begin
    vid_nxt = VOLTAGE_ID_CODE;
    ref_nxt = ref_r;
    if (VOLTAGE_ID_CODE != vid_r) ref_nxt = VOLTAGE_ID_CODE;
    atr_nxt.over  = ({1'b0, SENSE_CODE} > over_lvl);
    atr_nxt.under = (under_chk < {1'b0, ref_r});
  end

  // Register only; reference starts at the lowest code
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ref_r <= `TDFS_CODE_RST;
      vid_r <= `TDFS_CODE_RST;
      atr_r <= '0;
    end else begin
      ref_r <= ref_nxt;
      vid_r <= vid_nxt;
      atr_r <= atr_nxt;
    end
  end

  // trip from selection
  // Selections above the top step clamp to the highest trip point
  assign ot_sel_c = (OT_SEL > `TDFS_OT_MAX_SEL) ? `TDFS_OT_MAX_SEL : OT_SEL;
  assign ot_trip  = `TDFS_OT_BASE_C + 8'(`TDFS_OT_STEP_C * {5'h00, ot_sel_c});
  assign ot_rel   = ot_trip - `TDFS_OT_HYST_C;

  tdfs_hyst #(.W(16), .ABOVE(1'b0)) u_iuv (
    .clk     (CLOCK),
    .rst_b   (RST_B),
    .value   (VIN_MV),
    .trip    (`TDFS_IUV_SET_MV),
    .rel_lvl (`TDFS_IUV_CLR_MV),
    .flag    (iuv_flag)
  );

  // Overtemperature with its own hysteresis
  tdfs_hyst #(.W(8), .ABOVE(1'b1)) u_ot (
    .clk     (CLOCK),
    .rst_b   (RST_B),
    .value   (TEMP_C),
    .trip    (ot_trip),
    .rel_lvl (ot_rel),
    .flag    (ot_flag)
  );

  // live status bits
  // Live status; voltage bits come straight from the window
  always_comb begin
    status_live.iuv = iuv_flag;
    status_live.ouv = (ouv_chk < {1'b0, ref_r});
    status_live.oov = ({1'b0, SENSE_CODE} > oov_lvl);
    status_live.ot  = ot_flag;
  end

  // sticky fault bits
  // Set wins over clear so a fault in the clear cycle is kept
  always_comb begin
    fault_nxt = FAULT_CLR ? `TDFS_FAULT_RST : fault_r;
    fault_nxt = fault_nxt | status_live;
  end

  // Register only
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) fault_r <= `TDFS_FAULT_RST;
    else fault_r <= fault_nxt;
  end

  assign ilim = IW'(ILIM_BASE) + IW'(ILIM_STEP * int'(ILIM_SEL));

  // pulse-by-pulse cut
  // The cut never touches the fault register: it is not a shutdown
  always_comb begin
    cut_nxt = cut_r;
    if (PERIOD_START) cut_nxt = 1'b0;
    // Overcurrent in the first cycle of a period still cuts
    if (PWM_IN && PHASE_CURRENT > ilim) cut_nxt = 1'b1;
    hs_nxt = PWM_IN & ~cut_nxt;
  end

  // Register only
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      cut_r <= 1'b0;
      hs_r  <= 1'b0;
    end else begin
      cut_r <= cut_nxt;
      hs_r  <= hs_nxt;
    end
  end

  // Outputs from flip-flops, except STATUS, which is gated by the live comparators
  assign ATR_PULSE     = atr_r;
  assign TRANSIENT_REF = ref_r;
  assign STATUS        = {iuv_flag, fault_r.ouv, fault_r.oov, ot_flag} & status_live;
  assign FAULT_REG     = fault_r;
  assign HS_GATE       = hs_r;

  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  // Overcurrent followed by the cut holding
  sequence s_overcurrent;
    PWM_IN && (PHASE_CURRENT > ilim) && !PERIOD_START;
  endsequence
  sequence s_cut_hold;
    !HS_GATE [*2];
  endsequence

  AST_OVER_PULSE: assert property (
    ({1'b0, SENSE_CODE} > over_lvl) |=> ATR_PULSE.over)
    else $error("overshoot pulse missing");
  AST_UNDER_PULSE: assert property (
    (under_chk >= {1'b0, ref_r}) |=> !ATR_PULSE.under)
    else $error("undershoot pulse while inside window");
  AST_REF_TRACK: assert property (
    (VOLTAGE_ID_CODE != vid_r) |=> (TRANSIENT_REF == $past(VOLTAGE_ID_CODE)))
    else $error("reference did not follow voltage code");
  AST_OFS_STEP: assert property (
    (SENSE_CODE == ref_r + SW'(OVER_OFS) + 1'b1) && (ref_r < 8'hC0) |=> ATR_PULSE.over)
    else $error("overshoot offset step wrong");
  AST_FAULT_STICKY: assert property (
    FAULT_REG.oov && !FAULT_CLR |=> FAULT_REG.oov)
    else $error("fault bit lost without clear");
  AST_OOV_SET: assert property (
    ({1'b0, SENSE_CODE} > oov_lvl) && FAULT_CLR |=> FAULT_REG.oov)
    else $error("overvoltage fault not kept over clear");
  AST_PEAK_CUT: assert property (
    s_overcurrent ##1 (!PERIOD_START [*2]) |-> s_cut_hold)
    else $error("high side not cut after overcurrent");
  AST_ILIM_STEPS: assert property (
    PWM_IN && !cut_r && (int'(PHASE_CURRENT) <= ILIM_BASE + ILIM_STEP * int'(ILIM_SEL))
    |=> HS_GATE)
    else $error("peak limit step wrong");
  AST_OT_SET: assert property (
    (TEMP_C >= ot_trip) |=> ##1 FAULT_REG.ot)
    else $error("overtemperature not recorded");
  AST_IUV_HYST: assert property (
    STATUS.iuv && (VIN_MV <= `TDFS_IUV_CLR_MV) |=> STATUS.iuv)
    else $error("input undervoltage cleared below release level");

endmodule : tdfs_stage
